// >>> rtl/ddremr_top.sv
// Extended mode register load: holds DLL and drive strength controls.
// Assumes the controller keeps its own sequencing and idle-bank duties.
// Functional notes
// - Bank select low picks extended or ordinary register.
// - Command is all four strobes low together with clock enable high.
// - Latch address and bank lines on decode edge.
// - Address bit one selects driver strength.
// - Rewrites allowed during operation when banks idle.
// - Address bit zero controls the DLL.
// - Ordinary write has bank select bit zero low; bit one is ignored.
`include "ddremr_map.svh"
module ddremr_top
    import ddremr_pkg::*;
#(
    parameter int UPDATE_NS = `DDREMR_UPDATE_NS
)
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Command pins
    input wire logic i_cs_n,
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_we_n,
    input wire logic i_cke,
    input wire logic [`DDREMR_ADDR_W-1:0] i_addr,
    input wire logic [`DDREMR_BANK_W-1:0] i_bank,
    // Register contents
    output logic [`DDREMR_ADDR_W-1:0] o_ext_mode,
    output logic [`DDREMR_BANK_W-1:0] o_ext_bank,
    output logic [`DDREMR_ADDR_W-1:0] o_mode,
    output logic o_ext_valid,
    // Decoded controls
    output logic o_dll_enable,
    output ddremr_drive_type o_drive,
    output logic o_busy
);
    import ddremr_pkg::*;

    // Two cycles of update time, rounded up
    localparam int UPD_CYC_RAW =
        (UPDATE_NS + `DDREMR_CLK_NS - 1) / `DDREMR_CLK_NS;
    localparam int UPD_CYC = (UPD_CYC_RAW < 1) ? 1 : UPD_CYC_RAW;

    ddremr_cmd_if cmd ();

    ddremr_decode u_decode
    (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_cs_n(i_cs_n),
        .i_ras_n(i_ras_n),
        .i_cas_n(i_cas_n),
        .i_we_n(i_we_n),
        .i_cke(i_cke),
        .i_addr(i_addr),
        .i_bank(i_bank),
        .o_cmd(cmd)
    );

    // Contents are undefined at power-up, so the data holds no reset;
    // only the valid flag and the update timer are reset.
    logic [`DDREMR_ADDR_W-1:0] ext_r, ext_nxt, mode_r, mode_nxt;
    logic [`DDREMR_BANK_W-1:0] bank_r, bank_nxt;
    logic valid_r, valid_nxt;
    ddremr_state_type st_r, st_nxt;
    logic [7:0] cnt_r, cnt_nxt;

    always_comb
    begin
        ext_nxt = ext_r;
        bank_nxt = bank_r;
        mode_nxt = mode_r;
        if (cmd.load_ext)
        begin
            ext_nxt = cmd.addr;
            bank_nxt = cmd.bank;
        end
        if (cmd.load_mode)
        begin
            mode_nxt = cmd.addr;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        ext_r <= ext_nxt;
        bank_r <= bank_nxt;
        mode_r <= mode_nxt;
    end

    always_comb
    begin
        valid_nxt = valid_r | cmd.load_ext;
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            DDREMR_ST_IDLE:
            begin
                if (cmd.load_ext)
                begin
                    st_nxt = DDREMR_ST_BUSY;
                    cnt_nxt = 8'(UPD_CYC - 1);
                end
            end
            DDREMR_ST_BUSY:
            begin
                if (cnt_r == 8'h00)
                begin
                    st_nxt = DDREMR_ST_DONE;
                end
                else
                begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            DDREMR_ST_DONE:
            begin
                st_nxt = DDREMR_ST_IDLE;
            end
            default:
            begin
                st_nxt = DDREMR_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            valid_r <= 1'b0;
            st_r <= DDREMR_ST_IDLE;
            cnt_r <= 8'h00;
        end
        else
        begin
            valid_r <= valid_nxt;
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign o_ext_mode = ext_r;
    assign o_ext_bank = bank_r;
    assign o_mode = mode_r;
    assign o_ext_valid = valid_r;
    // Update window; controller must not command during it
    assign o_busy = (st_r == DDREMR_ST_BUSY);
    // Undefined before first write: report DLL on only once loaded
    assign o_dll_enable = valid_r &&
        !ext_r[`DDREMR_DLL_BIT];
    assign o_drive = ext_r[`DDREMR_DRIVE_BIT] ? DDREMR_DRV_WEAK
        : DDREMR_DRV_NORMAL;
endmodule

// >>> common/ddremr_map.svh
// Constants for the extended mode register load block.
// Assumes a single core clock; included by bare name.
`ifndef DDREMR_MAP_SVH
`define DDREMR_MAP_SVH
`define DDREMR_ADDR_W 12
`define DDREMR_BANK_W 2
`define DDREMR_DLL_BIT 0
`define DDREMR_DRIVE_BIT 1
`define DDREMR_BANK_LOW_BIT 0
`define DDREMR_UPDATE_NS 100
`define DDREMR_CLK_NS 50
`endif

// >>> common/ddremr_pkg.sv
// Types for the extended mode register load block.
// Assumes the constants header is on the include path.
package ddremr_pkg;
    typedef enum logic [1:0] {
        DDREMR_DRV_NORMAL = 2'h0,
        DDREMR_DRV_WEAK = 2'h1
    } ddremr_drive_type;
    typedef enum logic [2:0] {
        DDREMR_ST_IDLE = 3'h1,
        DDREMR_ST_BUSY = 3'h2,
        DDREMR_ST_DONE = 3'h4
    } ddremr_state_type;
endpackage

// >>> common/ddremr_cmd_if.sv
// Carrier for a decoded mode register command between modules.
// Assumes all signals are on the core clock.
interface ddremr_cmd_if;
    logic load_ext;
    logic load_mode;
    logic [11:0] addr;
    logic [1:0] bank;
    modport src (output load_ext, output load_mode, output addr,
        output bank);
    modport dst (input load_ext, input load_mode, input addr,
        input bank);
endinterface

// >>> rtl/ddremr_decode.sv
// Command decoder: synchronises the pins and spots register writes.
// Assumes command pins come from outside the core clock domain.
`include "ddremr_map.svh"
module ddremr_decode
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Command pins
    input wire logic i_cs_n,
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_we_n,
    input wire logic i_cke,
    input wire logic [`DDREMR_ADDR_W-1:0] i_addr,
    input wire logic [`DDREMR_BANK_W-1:0] i_bank,
    // Decoded command
    ddremr_cmd_if.src o_cmd
);
    localparam int PW = 5 + `DDREMR_ADDR_W + `DDREMR_BANK_W;
    logic [PW-1:0] s1_r, s1_nxt, s2_r, s2_nxt;
    logic is_write;

    always_comb
    begin
        s1_nxt = {i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_addr, i_bank};
        s2_nxt = s1_r;
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s1_r <= '0;
            s2_r <= '0;
        end
        else
        begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
        end
    end

    // All four strobes low on one edge, clock enable high
    assign is_write = s2_r[PW-1] &&
        (s2_r[PW-2:PW-5] == 4'h0);
    assign o_cmd.addr = s2_r[`DDREMR_BANK_W +: `DDREMR_ADDR_W];
    assign o_cmd.bank = s2_r[`DDREMR_BANK_W-1:0];
    assign o_cmd.load_ext = is_write &&
        s2_r[`DDREMR_BANK_LOW_BIT];
    assign o_cmd.load_mode = is_write &&
        !s2_r[`DDREMR_BANK_LOW_BIT];
endmodule

// >>> verif/ddremr_checker.sv
// Port assertions for ddremr_top.
// Bound by name; one core clock, async reset.
module ddremr_checker
    import ddremr_pkg::*;
(
    input wire logic i_core_clk, i_rst, i_cs_n, i_ras_n, i_cas_n,
    input wire logic i_we_n, i_cke, o_ext_valid, o_dll_enable, o_busy,
    input wire logic [11:0] i_addr, o_ext_mode, o_mode,
    input wire logic [1:0] i_bank, o_ext_bank,
    input wire ddremr_pkg::ddremr_drive_type o_drive
);
    timeunit 1ns;
    timeprecision 1ps;
    wire cmd = !(i_cs_n | i_ras_n | i_cas_n | i_we_n) & i_cke;
    wire ext = cmd & i_bank[0];
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    property p_ext; ext |-> ##3 o_ext_mode == $past(i_addr, 3); endproperty
    a_ext: assert property (p_ext) else $error("ext data");
    property p_bnk; ext |-> ##3 o_ext_bank == $past(i_bank, 3); endproperty
    a_bnk: assert property (p_bnk) else $error("ext bank");
    property p_ord; cmd & !i_bank[0] |-> ##3 o_mode == $past(i_addr, 3);
    endproperty
    a_ord: assert property (p_ord) else $error("mode data");
    property p_val; ext |-> ##3 o_ext_valid; endproperty
    a_val: assert property (p_val) else $error("valid");
    // Only defined contents can be held stable
    property p_hld; !ext |-> ##3 !o_ext_valid || $stable(o_ext_mode);
    endproperty
    a_hld: assert property (p_hld) else $error("ext hold");
    property p_dll; o_ext_valid |-> o_dll_enable == !o_ext_mode[0];
    endproperty
    a_dll: assert property (p_dll) else $error("dll");
    property p_drv; o_ext_valid |-> o_drive == {1'b0, o_ext_mode[1]};
    endproperty
    a_drv: assert property (p_drv) else $error("drive");
    property p_bsy; $rose(o_busy) |-> $past(ext, 3) ##1 o_busy ##1 !o_busy;
    endproperty
    a_bsy: assert property (p_bsy) else $error("busy");
endmodule
bind ddremr_top ddremr_checker u_chk (.*);

// >>> verif/ddremr_ctrl.sv
// Controller stand-in for the mode register command pins.
// Pin order: cs, ras, cas, we, cke, bank, addr; moves 1 ns late.
module ddremr_ctrl
(
    input wire logic i_core_clk,
    output logic [18:0] o_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_pins = 19'h7c000;
    task automatic cmd(input logic [3:0] s, input logic k,
        input logic [1:0] b, input logic [11:0] a);
        @(posedge i_core_clk);
        #1;
        o_pins = {s, k, b, a};
        @(posedge i_core_clk);
        #1;
        // Released lines flip, so stale data never looks valid
        o_pins = {5'h1f, ~b, ~a};
        repeat (2) @(posedge i_core_clk);
    endtask
endmodule

// >>> verif/tb_top.sv
// Bench for ddremr_top driven by the controller stand-in.
// Checker is bound to the design; pins move 1 ns after the edge.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_cs_n, i_ras_n, i_cas_n, i_we_n, i_cke;
    logic o_ext_valid, o_dll_enable, o_busy;
    logic [11:0] i_addr, o_ext_mode, o_mode;
    logic [1:0] i_bank, o_ext_bank, o_drive;
    wire [18:0] pins;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    assign {i_cs_n, i_ras_n, i_cas_n, i_we_n, i_cke, i_bank, i_addr} = pins;
    initial
    begin
        forever #25 i_core_clk = ~i_core_clk;
    end
    ddremr_ctrl ctl (.i_core_clk, .o_pins(pins));
    ddremr_top DUT (.*);
    task automatic chk(input string n, input logic [11:0] e, s);
        num_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Whole run needs well under 100 cycles
    always @(posedge i_core_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic t_ext();
        for (int i = 0; i < 4; i++)
        begin
            ctl.cmd(4'h0, 1'b1, 2'h1, 12'(i));
            #1;
            chk("ext_mode", 12'(i), o_ext_mode);
            chk("ext_bank", 12'h001, 12'(o_ext_bank));
            chk("valid", 12'h001, 12'(o_ext_valid));
            chk("dll", 12'(!i[0]), 12'(o_dll_enable));
            chk("drive", 12'(i[1]), 12'(o_drive));
            chk("busy", 12'h001, 12'(o_busy));
        end
    endtask
    task automatic t_misc();
        ctl.cmd(4'h0, 1'b1, 2'h0, 12'h031);
        ctl.cmd(4'h1, 1'b1, 2'h1, 12'h000);
        ctl.cmd(4'h0, 1'b0, 2'h1, 12'h000);
        #1;
        chk("mode", 12'h031, o_mode);
        chk("ext_keep", 12'h003, o_ext_mode);
    endtask
    initial
    begin
        repeat (2) @(posedge i_core_clk);
        #1;
        i_rst = 1'b0;
        chk("valid", 1'b0, o_ext_valid);
        t_ext();
        t_misc();
        final_report();
    end
endmodule
